// ---- testbench/scg_cpu_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Processor side: idle instruction, pending interrupt, clock edges
// ----------------------------------------------------------------
module scg_cpu_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cpu_clock_out,
   input wire logic idle_cmd,
   input wire logic irq_cmd,
   output logic cpu_idle_exec,
   output logic cpu_irq_unmasked,
   output logic [15:0] cpu_edges
);
   logic idle_q;
   logic clk_q;

   // Idle instruction retires once per request, as a one-cycle pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_q <= 1'b0;
         cpu_idle_exec <= 1'b0;
      end else begin
         idle_q <= idle_cmd;
         cpu_idle_exec <= idle_cmd & ~idle_q;
      end
   end

   // Pending unmasked interrupt is a level until serviced
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_irq_unmasked <= 1'b0;
      end else begin
         cpu_irq_unmasked <= irq_cmd;
      end
   end

   // Count the clock edges the core really receives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_q <= 1'b0;
         cpu_edges <= 16'h0000;
      end else begin
         clk_q <= cpu_clock_out;
         cpu_edges <= cpu_edges + 16'(cpu_clock_out & ~clk_q);
      end
   end
endmodule
`default_nettype wire

// ---- testbench/system_clock_source_and_gating_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module system_clock_source_and_gating_tb;
   // PLL model locks at once, so the long lock wait is cut short
   localparam int LOCK_WAIT = 50;
   localparam logic [11:0] CA = scg_pkg::SCG_CTRL_ADDR;
   localparam logic [11:0] SA = scg_pkg::SCG_STATUS_ADDR;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, er, ext = 0, rtc = 0, pll = 0, strap = 1, alive = 1;
   logic idle_cmd = 0, irq_cmd = 0, idle_exec, irq_un, mon = 0, ls = 0, lr = 0, lob = 0;
   scg_pkg::scg_wake_t wake = 4'h0;
   logic ref_clk, sys_clk, cpu_clk, obs, obs_oe_n, pll_pd, usb_pd, rtc_en;
   logic [15:0] cpu_edges;
   int fail_count = 0, checked = 0, cnt_sys = 0, cnt_ref = 0, cnt_obs = 0, run = 0;
   int d_sys, d_ref, d_cpu, d_obs;

   always #4 pclk = ~pclk;
   always #40 ext = ~ext;
   always #24 pll = ~pll;
   always #200 rtc = ~rtc;

   scg_clock_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_ref_clock_pin(ext), .rtc_clock_in(rtc), .pll_clock_in(pll),
      .ref_source_select_pin(strap), .rtc_osc_alive_pin(alive), .wake_pins(wake),
      .cpu_idle_exec(idle_exec), .cpu_irq_unmasked(irq_un), .ref_input_clock(ref_clk),
      .system_clock_out(sys_clk), .cpu_clock_out(cpu_clk), .clock_observe_pin(obs),
      .clock_observe_oe_n(obs_oe_n), .pll_power_down(pll_pd),
      .usb_osc_power_down(usb_pd), .rtc_access_enable(rtc_en));
   scg_cpu_model cpu (.pclk(pclk), .presetn(presetn), .cpu_clock_out(cpu_clk),
      .idle_cmd(idle_cmd), .irq_cmd(irq_cmd), .cpu_idle_exec(idle_exec),
      .cpu_irq_unmasked(irq_un), .cpu_edges(cpu_edges));

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task chk_rng(input string n, input int lo, input int hi, input int g);
      checked++;
      if (g < lo || g > hi) begin
         fail_count++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", n, lo, hi, g);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // Rising edges seen on each clock over a window of n cycles
   task rate(input int n);
      int s0, r0, o0;
      logic [15:0] c0;
      s0 = cnt_sys;
      r0 = cnt_ref;
      o0 = cnt_obs;
      c0 = cpu_edges;
      repeat (n) @(posedge pclk);
      d_sys = cnt_sys - s0;
      d_ref = cnt_ref - r0;
      d_obs = cnt_obs - o0;
      d_cpu = 16'(cpu_edges - c0);
   endtask
   // ----------------------------------------------------------------
   // Edge counters and shortest-pulse monitor on the system clock
   // ----------------------------------------------------------------
   always @(posedge pclk) begin
      cnt_sys += int'(sys_clk & ~ls);
      cnt_ref += int'(ref_clk & ~lr);
      cnt_obs += int'(obs & ~lob);
      if (sys_clk === ls) run++;
      else begin
         if (mon) chk_rng("sys_pulse", 3, 100000, run);
         run = 1;
      end
      ls = sys_clk;
      lr = ref_clk;
      lob = obs;
   end

   task t_reset;
      chk("pll_pd_pin", 1, pll_pd);
      chk("usb_pd_pin", 1, usb_pd);
      chk("pready_idle", 1, pready);
      apb(0, CA, 0);
      chk("ctrl_reset", 32'h0000_0002, rd);
      apb(1, 12'h008, 32'hFFFF_FFFF);
      chk("unmapped_err", 1, er);
      apb(0, 12'h008, 0);
      chk("unmapped_rd", 0, rd);
      apb(0, CA, 0);
      chk("ctrl_kept", 32'h0000_0002, rd);
      chk("obs_oe_reset", 0, obs_oe_n);
   endtask
   task t_bypass;
      rate(400);
      chk_rng("ref_rate", 38, 42, d_ref);
      chk_rng("sys_bypass", 38, 42, d_sys);
      chk_rng("obs_rate", 38, 42, d_obs);
      apb(1, CA, 32'h0000_0003);
      repeat (20) @(posedge pclk);
      apb(0, SA, 0);
      chk("strap_ext", 1, rd[4]);
      chk("failsafe", 0, rd[0]);
      rate(400);
      chk_rng("sys_failsafe", 38, 42, d_sys);
   endtask
   task t_pll;
      apb(1, CA, 0);
      @(posedge pclk);
      chk("pll_up", 0, pll_pd);
      repeat (LOCK_WAIT) @(posedge pclk);
      apb(1, CA, 32'h0000_0001);
      repeat (30) @(posedge pclk);
      apb(0, SA, 0);
      chk("pll_active", 1, rd[0]);
      rate(400);
      chk_rng("sys_pll", 64, 69, d_sys);
      apb(1, CA, 0);
      repeat (30) @(posedge pclk);
      rate(400);
      chk_rng("sys_back", 38, 42, d_sys);
      apb(1, CA, 32'h0000_0002);
      @(posedge pclk);
      chk("pll_down", 1, pll_pd);
   endtask
   task t_gate;
      mon = 0; // a gate may legally cut a pulse
      for (int i = 0; i < 4; i++) begin
         apb(1, CA, 32'h0000_0006);
         repeat (6) @(posedge pclk);
         rate(60);
         chk("sys_gated", 0, d_sys);
         chk("cpu_gated", 0, d_cpu);
         chk("sys_low", 0, sys_clk);
         wake <= 4'(1 << i);
         repeat (8) @(posedge pclk);
         wake <= 4'h0;
         apb(0, CA, 0);
         chk("wake_clear", 0, rd[2]);
         rate(200);
         chk_rng("sys_woken", 18, 22, d_sys);
      end
      mon = 1;
   endtask
   task pulse_idle;
      idle_cmd <= 1;
      @(posedge pclk);
      idle_cmd <= 0;
      repeat (6) @(posedge pclk);
   endtask
   task t_idle;
      pulse_idle;
      rate(200);
      chk_rng("cpu_no_gate", 18, 22, d_cpu);
      apb(1, CA, 32'h0000_000A);
      rate(200);
      chk_rng("cpu_armed", 18, 22, d_cpu);
      pulse_idle;
      rate(200);
      chk("cpu_idle", 0, d_cpu);
      chk_rng("sys_idle", 18, 22, d_sys);
      apb(0, SA, 0);
      chk("cpu_off_st", 1, rd[3]);
      irq_cmd <= 1;
      repeat (6) @(posedge pclk);
      irq_cmd <= 0;
      rate(200);
      chk_rng("cpu_irq", 18, 22, d_cpu);
   endtask
   task t_misc;
      chk("rtc_on", 1, rtc_en);
      apb(1, CA, 32'h0000_0032);
      repeat (4) @(posedge pclk);
      chk("usb_en", 0, usb_pd);
      chk("obs_hiz", 1, obs_oe_n);
      alive <= 0;
      repeat (6) @(posedge pclk);
      chk("rtc_off", 0, rtc_en);
      alive <= 1;
      repeat (6) @(posedge pclk);
      chk("rtc_back", 1, rtc_en);
   endtask
   // Second reset with the strap changed while reset is held
   task t_strap;
      mon = 0; // reset cuts the running clock
      presetn <= 0;
      strap <= 0;
      repeat (8) @(posedge pclk);
      presetn <= 1;
      repeat (100) @(posedge pclk);
      apb(0, SA, 0);
      chk("strap_rtc", 0, rd[4]);
      chk("pll_pd_again", 1, pll_pd);
      mon = 1;
      rate(800);
      chk_rng("ref_rtc", 15, 17, d_ref);
      chk_rng("sys_rtc", 15, 17, d_sys);
   endtask

   initial begin
      repeat (60000) @(posedge pclk);
      fail_count++;
      end_sim;
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1; // strap held fixed until t_strap
      @(posedge pclk);
      t_reset;
      // Start-up may cut the first reference pulse; judge pulses from here
      mon = 1;
      t_bypass;
      t_pll;
      t_gate;
      t_idle;
      t_misc;
      t_strap;
      end_sim;
   end
endmodule
`default_nettype wire

// ---- verilog/scg_clock_ctrl.sv ----
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module scg_clock_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_ref_clock_pin,
   input wire logic rtc_clock_in,
   input wire logic pll_clock_in,
   input wire logic ref_source_select_pin,
   input wire logic rtc_osc_alive_pin,
   input wire scg_pkg::scg_wake_t wake_pins,
   input wire logic cpu_idle_exec,
   input wire logic cpu_irq_unmasked,
   output logic ref_input_clock,
   output logic system_clock_out,
   output logic cpu_clock_out,
   output logic clock_observe_pin,
   output logic clock_observe_oe_n,
   output logic pll_power_down,
   output logic usb_osc_power_down,
   output logic rtc_access_enable
);
   scg_pkg::scg_ctrl_t ctrl_r;
   logic [2:0] clk_s;
   logic strap_s;
   logic rtc_alive_s;
   scg_pkg::scg_wake_t wake_s;
   logic ref_sel_r;
   logic strap_taken_r;
   logic [1:0] strap_fill_r;
   logic sel_eff;
   logic mux_clk;
   logic mux_cur;
   logic mux_busy;
   logic sys_off_r;
   logic cpu_off_r;
   logic wake_any;
   logic ref_lvl;
   logic wr_ctrl;
   logic rd_setup;
   logic unmapped;
   logic [31:0] status;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Clock pins are oversampled; usable while they stay well below pclk/2.
   scg_sync #(.W(3)) u_clk_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({pll_clock_in, rtc_clock_in, ext_ref_clock_pin}),
      .q(clk_s)
   );

   scg_sync #(.W(6)) u_pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({wake_pins, rtc_osc_alive_pin, ref_source_select_pin}),
      .q({wake_s, rtc_alive_s, strap_s})
   );

   // ----------------------------------------------------------------
   // Reference selection
   // ----------------------------------------------------------------
   // Strap is taken once, after the synchroniser has filled, so the
   // reset value of the sync stages is never mistaken for the pin.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_sel_r <= 1'b0;
         strap_taken_r <= 1'b0;
         strap_fill_r <= 2'h0;
      end else if (!strap_taken_r) begin
         strap_fill_r <= {strap_fill_r[0], 1'b1};
         if (strap_fill_r[1]) begin
            ref_sel_r <= strap_s;
            strap_taken_r <= 1'b1;
         end
      end
   end

   // No USB clock reaches this point: only pin or RTC
   assign ref_lvl = ref_sel_r ? clk_s[0] : clk_s[1];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_input_clock <= 1'b0;
      end else begin
         ref_input_clock <= ref_lvl;
      end
   end

   // ----------------------------------------------------------------
   // Bypass / PLL switch
   // ----------------------------------------------------------------
   // Failsafe: a PLL powered down before a switch to it completes is never picked up
   assign sel_eff = ctrl_r.pll_path_select & ~ctrl_r.pll_power_down;

   scg_glitch_mux u_mux (
      .pclk(pclk),
      .presetn(presetn),
      .src0(ref_lvl),
      .src1(clk_s[2]),
      .sel(sel_eff),
      .clk_o(mux_clk),
      .cur_o(mux_cur),
      .busy_o(mux_busy)
   );

   assign pll_power_down = ctrl_r.pll_power_down;

   // ----------------------------------------------------------------
   // Clock gates
   // ----------------------------------------------------------------
   assign wake_any = |wake_s;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_off_r <= 1'b0;
      end else if (wake_any) begin
         sys_off_r <= 1'b0;
      end else begin
         sys_off_r <= ctrl_r.master_clock_disable;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_off_r <= 1'b0;
      end else if (cpu_irq_unmasked) begin
         cpu_off_r <= 1'b0;
      end else if (cpu_idle_exec && ctrl_r.cpu_idle_clock_gate) begin
         cpu_off_r <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         system_clock_out <= 1'b0;
         cpu_clock_out <= 1'b0;
         clock_observe_pin <= 1'b0;
         clock_observe_oe_n <= 1'b0;
      end else begin
         system_clock_out <= mux_clk & ~sys_off_r;
         cpu_clock_out <= mux_clk & ~sys_off_r & ~cpu_off_r;
         clock_observe_pin <= mux_clk & ~sys_off_r;
         clock_observe_oe_n <= ctrl_r.clock_pin_output_off;
      end
   end

   // ----------------------------------------------------------------
   // Oscillator and RTC controls
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         usb_osc_power_down <= 1'b1;
         rtc_access_enable <= 1'b0;
      end else begin
         usb_osc_power_down <= ~ctrl_r.usb_osc_enable;
         rtc_access_enable <= rtc_alive_s;
      end
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // Zero wait states: simpler master timing, at the cost of a
   // registered read path taken in the setup cycle.
   assign unmapped = (paddr != scg_pkg::SCG_CTRL_ADDR) && (paddr != scg_pkg::SCG_STATUS_ADDR);
   assign pready = 1'b1;
   assign pslverr = psel & penable & unmapped;
   assign wr_ctrl = psel & penable & pwrite & (paddr == scg_pkg::SCG_CTRL_ADDR);
   assign rd_setup = psel & ~penable & ~pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= scg_pkg::SCG_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_r <= scg_pkg::scg_ctrl_t'(pwdata[scg_pkg::SCG_CTRL_WIDTH-1:0]);
         // Wake beats a write asking to stop the clock again
         if (wake_any) begin
            ctrl_r.master_clock_disable <= 1'b0;
         end
      end else if (wake_any) begin
         ctrl_r.master_clock_disable <= 1'b0;
      end
   end

   always_comb begin
      status = 32'h0000_0000;
      status[scg_pkg::SCG_ST_PLL_ACTIVE_BIT] = mux_cur;
      status[scg_pkg::SCG_ST_SWITCHING_BIT] = mux_busy;
      status[scg_pkg::SCG_ST_SYS_OFF_BIT] = sys_off_r;
      status[scg_pkg::SCG_ST_CPU_OFF_BIT] = cpu_off_r;
      status[scg_pkg::SCG_ST_REF_EXT_BIT] = ref_sel_r;
      status[scg_pkg::SCG_ST_RTC_ALIVE_BIT] = rtc_alive_s;
      status[scg_pkg::SCG_ST_USB_EN_BIT] = ctrl_r.usb_osc_enable;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         if (paddr == scg_pkg::SCG_CTRL_ADDR) begin
            prdata <= {{(32 - scg_pkg::SCG_CTRL_WIDTH){1'b0}}, ctrl_r};
         end else if (paddr == scg_pkg::SCG_STATUS_ADDR) begin
            prdata <= status;
         end else begin
            prdata <= scg_pkg::SCG_UNMAPPED_DATA;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   pll_failsafe_a: assert property (ctrl_r.pll_power_down && !mux_cur |=> !mux_cur)
      else $error("powered-down PLL was selected");

   reset_pd_a: assert property ($rose(presetn) |-> ctrl_r.pll_power_down)
      else $error("PLL power-down not set after reset");

   reset_bypass_a: assert property ($rose(presetn) |->
      !ctrl_r.pll_path_select && !mux_cur)
      else $error("bypass not active after reset");

   master_gate_a: assert property (sys_off_r |=> !system_clock_out && !cpu_clock_out)
      else $error("system clock runs while gated");

   sequence wake_seen_s;
      sys_off_r ##0 wake_any;
   endsequence

   wake_restart_a: assert property (wake_seen_s |=> !sys_off_r ##1 !sys_off_r)
      else $error("wake did not restart system clock");

   idle_gate_a: assert property ($rose(cpu_off_r) |->
      $past(cpu_idle_exec) && $past(ctrl_r.cpu_idle_clock_gate))
      else $error("CPU clock gated without idle");

   irq_restore_a: assert property (cpu_off_r && cpu_irq_unmasked |=> !cpu_off_r)
      else $error("interrupt did not restore CPU clock");

   usb_down_a: assert property (!ctrl_r.usb_osc_enable |=> usb_osc_power_down)
      else $error("USB oscillator powered without enable");

   clkpin_off_a: assert property (ctrl_r.clock_pin_output_off |=> clock_observe_oe_n)
      else $error("observation pin driven while off");

   rtc_block_a: assert property (!rtc_alive_s |=> !rtc_access_enable)
      else $error("RTC window open with oscillator off");

   strap_once_a: assert property (strap_taken_r |=> $stable(ref_sel_r))
      else $error("reference choice changed after capture");

   ext_ref_a: assert property (strap_taken_r && ref_sel_r |=>
      ref_input_clock == $past(clk_s[0]))
      else $error("reference does not follow the clock pin");

   rtc_ref_a: assert property (strap_taken_r && !ref_sel_r |=>
      ref_input_clock == $past(clk_s[1]))
      else $error("reference does not follow the RTC clock");

   cpu_under_sys_a: assert property (!system_clock_out |-> !cpu_clock_out)
      else $error("CPU clock runs without system clock");

   wake_clears_a: assert property (wake_any |=> !ctrl_r.master_clock_disable)
      else $error("wake left master disable set");
endmodule
`default_nettype wire

// ---- verilog/scg_glitch_mux.sv ----
`timescale 1ns/1ns
`default_nettype none
module scg_glitch_mux (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic src0,
   input wire logic src1,
   input wire logic sel,
   output logic clk_o,
   output logic cur_o,
   output logic busy_o
);
   typedef enum logic [2:0] {
      GM_RUN = 3'b001,
      GM_ARM = 3'b010,
      GM_DRAIN = 3'b100
   } scg_gm_state_t;

   scg_gm_state_t state_r;
   logic cur_r;
   logic tgt_r;
   logic cur_lvl;
   logic tgt_lvl;

   assign cur_lvl = cur_r ? src1 : src0;
   assign tgt_lvl = tgt_r ? src1 : src0;
   assign cur_o = cur_r;
   assign busy_o = (state_r != GM_RUN);

   // ----------------------------------------------------------------
   // Switch sequencer
   // ----------------------------------------------------------------
   // Leave the old source only while it is low, then wait a whole
   // high-low cycle of the new one, so neither phase is ever cut short.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= GM_RUN;
         cur_r <= 1'b0;
         tgt_r <= 1'b0;
      end else begin
         case (state_r)
            GM_RUN: begin
               if (sel != cur_r && !cur_lvl) begin
                  tgt_r <= sel;
                  state_r <= GM_ARM;
               end
            end
            GM_ARM: begin
               if (sel == cur_r) begin
                  // Abandoned switch: rejoin the old source only while it is low
                  if (!cur_lvl) begin
                     state_r <= GM_RUN;
                  end
               end else if (tgt_lvl) begin
                  state_r <= GM_DRAIN;
               end
            end
            GM_DRAIN: begin
               if (sel == cur_r) begin
                  // A PLL powered down mid-switch is never taken on
                  if (!cur_lvl) begin
                     state_r <= GM_RUN;
                  end
               end else if (!tgt_lvl) begin
                  cur_r <= tgt_r;
                  state_r <= GM_RUN;
               end
            end
            default: state_r <= GM_RUN;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_o <= 1'b0;
      end else begin
         clk_o <= (state_r == GM_RUN) ? cur_lvl : 1'b0;
      end
   end

   sequence switch_start_s;
      state_r == GM_RUN && sel != cur_r && !cur_lvl;
   endsequence

   sequence parked_s;
      !clk_o [*2];
   endsequence

   property no_short_pulse_p;
      @(posedge pclk) disable iff (!presetn) switch_start_s |=> parked_s;
   endproperty

   glitch_free_sw_a: assert property (no_short_pulse_p)
      else $error("clock switch output not parked low");

   bypass_route_a: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == GM_RUN && !cur_r |=> clk_o == $past(src0))
      else $error("bypass path does not follow reference");
endmodule
`default_nettype wire

// ---- verilog/scg_pkg.sv ----
`default_nettype none
package scg_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [11:0] SCG_CTRL_ADDR = 12'h000;
   localparam logic [11:0] SCG_STATUS_ADDR = 12'h004;

   // ----------------------------------------------------------------
   // Control register field positions
   // ----------------------------------------------------------------
   localparam int SCG_PATH_SEL_BIT = 0;
   localparam int SCG_PLL_PD_BIT = 1;
   localparam int SCG_MASTER_DIS_BIT = 2;
   localparam int SCG_IDLE_GATE_BIT = 3;
   localparam int SCG_USB_EN_BIT = 4;
   localparam int SCG_CLK_OFF_BIT = 5;
   localparam int SCG_CTRL_WIDTH = 6;

   // ----------------------------------------------------------------
   // Status register field positions
   // ----------------------------------------------------------------
   localparam int SCG_ST_PLL_ACTIVE_BIT = 0;
   localparam int SCG_ST_SWITCHING_BIT = 1;
   localparam int SCG_ST_SYS_OFF_BIT = 2;
   localparam int SCG_ST_CPU_OFF_BIT = 3;
   localparam int SCG_ST_REF_EXT_BIT = 4;
   localparam int SCG_ST_RTC_ALIVE_BIT = 5;
   localparam int SCG_ST_USB_EN_BIT = 6;

   typedef struct packed {
      logic clock_pin_output_off;
      logic usb_osc_enable;
      logic cpu_idle_clock_gate;
      logic master_clock_disable;
      logic pll_power_down;
      logic pll_path_select;
   } scg_ctrl_t;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam scg_ctrl_t SCG_CTRL_RESET = 6'h02;
   localparam logic [31:0] SCG_UNMAPPED_DATA = 32'h0000_0000;

   typedef struct packed {
      logic rtc_irq;
      logic ext_irq_pin_b;
      logic ext_irq_pin_a;
      logic wake_pin;
   } scg_wake_t;

endpackage
`default_nettype wire

// ---- verilog/scg_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module scg_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // Two stages; nothing but the second stage reads the first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire
